// >>> core/pflb_pkg.sv
package pflb_pkg;

	// Register offsets on the byte-wide register port
	localparam logic [7:0] PFLB_OFS_FAULT_COUNTERS = 8'h1c;
	localparam logic [7:0] PFLB_OFS_FAULT_PATH = 8'h1d;
	localparam logic [7:0] PFLB_OFS_FAULT_REMOTE = 8'h1e;
	localparam logic [7:0] PFLB_OFS_MON_COUNTERS = 8'h18;
	localparam logic [7:0] PFLB_OFS_MON_PATH = 8'h19;
	localparam logic [7:0] PFLB_OFS_MON_REMOTE = 8'h1a;

	// Reset value of the read data, and read value of unmapped and reserved bits
	localparam logic [7:0] PFLB_RESET_VALUE = 8'h00;
	localparam logic [7:0] PFLB_UNMAPPED_VALUE = 8'h00;

	// Number of tracked events and their index in the event vector
	localparam int PFLB_NUM_EVENTS = 11;
	localparam int PFLB_IDX_CODE_VIOLATION = 0;
	localparam int PFLB_IDX_PATH_LO = 1;
	localparam int PFLB_IDX_PATH_HI = 8;
	localparam int PFLB_IDX_SERVER_DEFECT = 9;
	localparam int PFLB_IDX_PAYLOAD_DEFECT = 10;

	// Field positions inside the registers
	localparam int PFLB_BIT_CODE_VIOLATION = 0;
	localparam int PFLB_BIT_SERVER_DEFECT = 1;
	localparam int PFLB_BIT_PAYLOAD_DEFECT = 2;
	localparam logic [7:0] PFLB_REMOTE_RESERVED_MASK = 8'hf8;

	// Event inputs; the first field is the most significant bit
	typedef struct packed {
		logic remote_payload_defect_event;
		logic remote_server_defect_event;
		logic far_end_error_overflow_event;
		logic parity_error_overflow_event;
		logic tributary_alarm_event;
		logic pointer_loss_event;
		logic remote_failure_event;
		logic unequipped_label_event;
		logic label_mismatch_event;
		logic remote_defect_event;
		logic code_violation_overflow_event;
	} pflb_events_s;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} pflb_bus_s;

	// Fault latch bits as seen by the device
	typedef struct packed {
		logic remote_payload_defect_fault;
		logic remote_server_defect_fault;
		logic far_end_error_overflow_fault;
		logic parity_error_overflow_fault;
		logic tributary_alarm_fault;
		logic pointer_loss_fault;
		logic remote_failure_fault;
		logic unequipped_label_fault;
		logic label_mismatch_fault;
		logic remote_defect_fault;
		logic code_violation_overflow_fault;
	} pflb_faults_s;

endpackage

// >>> core/pflb_persist.sv
module pflb_persist
	import pflb_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic event_in,
	input wire logic strobe,
	output logic fault_hit,
	output logic monitor_hit
);

	typedef struct packed {
		logic prev;
		logic edge_seen;
		logic active_seen;
	} pflb_persist_s;

	pflb_persist_s st;
	pflb_persist_s next_st;
	logic rising;

	// Activation edge in this cycle belongs to the interval now running
	assign rising = event_in & ~st.prev;

	// Persistent: active at the boundary with no activation in the interval
	assign fault_hit = strobe & event_in & ~st.edge_seen & ~rising; // R15
	// Occurred: active at any time in the interval
	assign monitor_hit = strobe & (st.active_seen | event_in);

	// Interval bookkeeping, restarted at every strobe
	always_comb begin
		next_st = st;
		next_st.prev = event_in;
		if (strobe) begin // R16
			next_st.edge_seen = 1'b0;
			next_st.active_seen = 1'b0;
		end else begin
			next_st.edge_seen = st.edge_seen | rising;
			next_st.active_seen = st.active_seen | event_in;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

endmodule

// >>> core/pflb_bank.sv
// Contract
// R1 - Counter register bit 0: code violation persistence
// R2 - Path bit 7: far-end error overflow persistence
// R3 - Path bit 6: parity error overflow persistence
// R4 - Path bit 5: tributary alarm persistence
// R5 - Path bit 4: pointer loss persistence
// R6 - Path bit 3: remote failure persistence
// R7 - Path bit 2: unequipped label persistence
// R8 - Path bit 1: label mismatch persistence
// R9 - Path bit 0: remote defect persistence
// R10 - Remote bit 2: payload defect persistence
// R11 - Remote bit 1: server defect persistence
// R12 - Software writes zeros to remote bits 7-3
// R13 - Latch only while monitor enable is one
// R14 - Writing zero clears; set bits otherwise stay
// R15 - Judge persistence over one-second strobe intervals
// R16 - Check at each strobe; reset clears all
// R17 - Monitor bits set if event occurred
module pflb_bank
	import pflb_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 8
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire pflb_bus_s bus,
	input wire pflb_events_s events,
	input wire logic one_second_strobe,
	input wire logic monitor_latch_enable,
	output logic [7:0] rdata,
	output logic rd_ack,
	output pflb_faults_s faults,
	output logic [PFLB_NUM_EVENTS-1:0] monitors
);

	// Elaboration checks on the port geometry
	if (DATA_W != 8) begin : g_bad_data
		$error("pflb_bank: DATA_W must be 8");
	end
	if (ADDR_W != 8) begin : g_bad_addr
		$error("pflb_bank: ADDR_W must be 8");
	end

	typedef struct packed {
		logic [PFLB_NUM_EVENTS-1:0] fault;
		logic [PFLB_NUM_EVENTS-1:0] mon;
		logic [7:0] rdata;
		logic rd_ack;
	} pflb_bank_s;

	pflb_bank_s st;
	pflb_bank_s next_st;

	logic [PFLB_NUM_EVENTS-1:0] ev_vec;
	logic [PFLB_NUM_EVENTS-1:0] fault_hit;
	logic [PFLB_NUM_EVENTS-1:0] monitor_hit;
	logic [PFLB_NUM_EVENTS-1:0] fault_clr;
	logic [PFLB_NUM_EVENTS-1:0] mon_clr;
	logic [PFLB_NUM_EVENTS-1:0] fault_set;
	logic [PFLB_NUM_EVENTS-1:0] mon_set;
	logic [7:0] rd_value;

	// Events are a flat vector, code violation in bit 0
	assign ev_vec = events;

	// One persistence tracker per event
	for (genvar i = 0; i < PFLB_NUM_EVENTS; i++) begin : g_track
		pflb_persist u_persist (
			.clk(clk),
			.rstn(rstn),
			.ce(ce),
			.event_in(ev_vec[i]),
			.strobe(one_second_strobe),
			.fault_hit(fault_hit[i]),
			.monitor_hit(monitor_hit[i])
		);
	end

	// Latch requests gated by the monitoring enable
	assign fault_set = fault_hit & {PFLB_NUM_EVENTS{monitor_latch_enable}}; // R13
	assign mon_set = monitor_hit & {PFLB_NUM_EVENTS{monitor_latch_enable}}; // R17

	// Clear masks: a zero written in a bit position clears that bit
	always_comb begin
		fault_clr = '0;
		mon_clr = '0;
		if (bus.wr) begin
			case (bus.addr)
				PFLB_OFS_FAULT_COUNTERS: begin
					fault_clr[PFLB_IDX_CODE_VIOLATION] = ~bus.wdata[PFLB_BIT_CODE_VIOLATION]; // R14
				end
				PFLB_OFS_FAULT_PATH: begin
					fault_clr[PFLB_IDX_PATH_HI:PFLB_IDX_PATH_LO] = ~bus.wdata; // R14
				end
				PFLB_OFS_FAULT_REMOTE: begin
					// Upper bits are reserved and expected as zeros
					fault_clr[PFLB_IDX_SERVER_DEFECT] = ~bus.wdata[PFLB_BIT_SERVER_DEFECT]; // R12
					fault_clr[PFLB_IDX_PAYLOAD_DEFECT] = ~bus.wdata[PFLB_BIT_PAYLOAD_DEFECT];
				end
				PFLB_OFS_MON_COUNTERS: begin
					mon_clr[PFLB_IDX_CODE_VIOLATION] = ~bus.wdata[PFLB_BIT_CODE_VIOLATION];
				end
				PFLB_OFS_MON_PATH: begin
					mon_clr[PFLB_IDX_PATH_HI:PFLB_IDX_PATH_LO] = ~bus.wdata;
				end
				PFLB_OFS_MON_REMOTE: begin
					mon_clr[PFLB_IDX_SERVER_DEFECT] = ~bus.wdata[PFLB_BIT_SERVER_DEFECT];
					mon_clr[PFLB_IDX_PAYLOAD_DEFECT] = ~bus.wdata[PFLB_BIT_PAYLOAD_DEFECT];
				end
				default: begin
					fault_clr = '0;
				end
			endcase
		end
	end

	// Read multiplexer; reserved and unmapped bits read as zero
	always_comb begin
		rd_value = PFLB_UNMAPPED_VALUE;
		case (bus.addr)
			PFLB_OFS_FAULT_COUNTERS: begin
				rd_value[PFLB_BIT_CODE_VIOLATION] = st.fault[PFLB_IDX_CODE_VIOLATION]; // R1
			end
			PFLB_OFS_FAULT_PATH: begin
				// Bits 7..0: far-end, parity, alarm, pointer, failure, unequipped,
				// mismatch, remote defect
				rd_value = st.fault[PFLB_IDX_PATH_HI:PFLB_IDX_PATH_LO]; // R2 R3 R4 R5 R6 R7 R8 R9
			end
			PFLB_OFS_FAULT_REMOTE: begin
				rd_value[PFLB_BIT_PAYLOAD_DEFECT] = st.fault[PFLB_IDX_PAYLOAD_DEFECT]; // R10
				rd_value[PFLB_BIT_SERVER_DEFECT] = st.fault[PFLB_IDX_SERVER_DEFECT]; // R11
			end
			PFLB_OFS_MON_COUNTERS: begin
				rd_value[PFLB_BIT_CODE_VIOLATION] = st.mon[PFLB_IDX_CODE_VIOLATION];
			end
			PFLB_OFS_MON_PATH: begin
				rd_value = st.mon[PFLB_IDX_PATH_HI:PFLB_IDX_PATH_LO];
			end
			PFLB_OFS_MON_REMOTE: begin
				rd_value[PFLB_BIT_PAYLOAD_DEFECT] = st.mon[PFLB_IDX_PAYLOAD_DEFECT];
				rd_value[PFLB_BIT_SERVER_DEFECT] = st.mon[PFLB_IDX_SERVER_DEFECT];
			end
			default: begin
				rd_value = PFLB_UNMAPPED_VALUE;
			end
		endcase
	end

	// Next state: a set in the clearing cycle wins over the clear
	always_comb begin
		next_st = st;
		next_st.fault = (st.fault & ~fault_clr) | fault_set; // R14 R16
		next_st.mon = (st.mon & ~mon_clr) | mon_set;
		next_st.rd_ack = bus.rd;
		if (bus.rd) begin
			next_st.rdata = rd_value;
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st.fault <= '0; // R16
			st.mon <= '0;
			st.rdata <= PFLB_RESET_VALUE;
			st.rd_ack <= 1'b0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign faults = st.fault;
	assign monitors = st.mon;
	assign rdata = st.rdata;
	assign rd_ack = st.rd_ack;

endmodule

// >>> sim/pflb_bank_assertions.sv
module pflb_bank_assertions
	import pflb_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire pflb_bus_s bus,
	input wire pflb_events_s events,
	input wire logic one_second_strobe,
	input wire logic monitor_latch_enable,
	input wire logic [7:0] rdata,
	input wire logic rd_ack,
	input wire pflb_faults_s faults,
	input wire logic [PFLB_NUM_EVENTS-1:0] monitors
);
	// Flat views of the event and fault structs
	wire logic [10:0] fv = faults;
	wire logic [10:0] ev = events;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Taken read of one offset, and a strobe with latching on
	sequence s_rd(a);
		ce && bus.rd && bus.addr == a;
	endsequence
	sequence s_stb;
		ce && one_second_strobe && monitor_latch_enable;
	endsequence
	// Read answers and register contents
	property p_ack; 1'b1 |=> rd_ack == ($past(ce) ? $past(bus.rd) : $past(rd_ack)); endproperty
	property p_cnt; s_rd(8'h1c) |=> rdata == {7'h00, $past(fv[0])}; endproperty
	property p_path; s_rd(8'h1d) |=> rdata == $past(fv[8:1]); endproperty
	property p_rem; s_rd(8'h1e) |=> rdata == {5'h00, $past(fv[10:9]), 1'b0}; endproperty
	// Latch behaviour around strobes, enable and writes
	property p_keep; !(ce && bus.wr) |=> ($past(fv) & ~fv) == 11'h000; endproperty
	property p_en;
		!monitor_latch_enable |=> (fv & ~$past(fv)) == 11'h000
			&& (monitors & ~$past(monitors)) == 11'h000;
	endproperty
	property p_mon; s_stb |=> (monitors & $past(ev)) == $past(ev); endproperty
	property p_new;
		1'b1 |=> (fv & ~$past(fv) & ~($past(ev) & {11{$past(ce && one_second_strobe)}}))
			== 11'h000;
	endproperty
	a_ack: assert property (p_ack) else $error("read acknowledge wrong");
	a_cnt: assert property (p_cnt) else $error("counter fault read wrong");
	a_path: assert property (p_path) else $error("path fault read wrong");
	a_rem: assert property (p_rem) else $error("remote fault read wrong");
	a_keep: assert property (p_keep) else $error("fault bit fell without write");
	a_en: assert property (p_en) else $error("bit set while disabled");
	a_mon: assert property (p_mon) else $error("monitor bit missed");
	a_new: assert property (p_new) else $error("fault set without event");
endmodule

// >>> sim/pflb_bank_tb_top.sv
module pflb_bank_tb_top
	import pflb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, ce, stb, en, rd_ack;
	pflb_bus_s bus;
	pflb_events_s events;
	pflb_faults_s faults;
	logic [7:0] rdata;
	logic [10:0] monitors;
	int error_cnt, cmp_count;
	pflb_bank dut_u (.clk(clk), .rstn(rstn), .ce(ce), .bus(bus), .events(events),
		.one_second_strobe(stb), .monitor_latch_enable(en), .rdata(rdata),
		.rd_ack(rd_ack), .faults(faults), .monitors(monitors));
	// Verdict and end of run
	task automatic complete_run;
		$display("errors=%0d compares=%0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Register port write and read
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		bus = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge clk);
		bus.wr = 1'b0;
	endtask
	// One counted comparison, unknowns fail
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		int i;
		@(negedge clk);
		bus.addr = a;
		bus.rd = 1'b1;
		@(negedge clk);
		bus.rd = 1'b0;
		for (i = 0; i < 4 && rd_ack !== 1'b1; i++) @(negedge clk);
		if (i == 4) begin
			error_cnt++;
			complete_run();
		end else begin
			chk({3'h0, rdata}, {3'h0, exp});
		end
	endtask
	// One-cycle interval strobe
	task automatic pulse;
		@(negedge clk);
		stb = 1'b1;
		@(negedge clk);
		stb = 1'b0;
	endtask
	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Main sequence
	initial begin
		{rstn, stb, error_cnt, cmp_count} = '0;
		{ce, en} = 2'b11;
		bus = '0;
		events = '0;
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		for (int k = 0; k < 8; k++) rd(8'(8'h18 + k), 8'h00);
		events = '1;
		pulse();
		rd(PFLB_OFS_FAULT_PATH, 8'h00);
		rd(PFLB_OFS_MON_PATH, 8'hff);
		rd(PFLB_OFS_MON_REMOTE, 8'h06);
		chk(faults, 11'h000);
		chk(monitors, 11'h7ff);
		pulse();
		chk(faults, 11'h7ff);
		rd(PFLB_OFS_FAULT_COUNTERS, 8'h01);
		rd(PFLB_OFS_FAULT_PATH, 8'hff);
		rd(PFLB_OFS_FAULT_REMOTE, 8'h06);
		wr(PFLB_OFS_FAULT_PATH, 8'hfe);
		rd(PFLB_OFS_FAULT_PATH, 8'hfe);
		wr(PFLB_OFS_FAULT_REMOTE, 8'h00);
		wr(PFLB_OFS_FAULT_REMOTE, 8'h06);
		rd(PFLB_OFS_FAULT_REMOTE, 8'h00);
		wr(PFLB_OFS_FAULT_PATH, 8'h00);
		wr(PFLB_OFS_FAULT_COUNTERS, 8'h00);
		en = 1'b0;
		pulse();
		rd(PFLB_OFS_FAULT_PATH, 8'h00);
		en = 1'b1;
		events = pflb_events_s'(11'h2aa);
		pulse();
		rd(PFLB_OFS_FAULT_COUNTERS, 8'h00);
		rd(PFLB_OFS_FAULT_PATH, 8'h55);
		rd(PFLB_OFS_FAULT_REMOTE, 8'h02);
		chk(faults, 11'h2aa);
		events = '0;
		@(negedge clk);
		events = '1;
		pulse();
		rd(PFLB_OFS_FAULT_PATH, 8'h55);
		rd(PFLB_OFS_FAULT_REMOTE, 8'h02);
		// Clock enable low freezes trackers and latches
		ce = 1'b0;
		pulse();
		ce = 1'b1;
		chk(faults, 11'h2aa);
		pulse();
		chk(faults, 11'h7ff);
		// Monitor bits clear by a zero write
		wr(PFLB_OFS_MON_PATH, 8'h00);
		rd(PFLB_OFS_MON_PATH, 8'h00);
		// Reset in mid-run clears every latch
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		chk(faults, 11'h000);
		chk(monitors, 11'h000);
		rd(PFLB_OFS_MON_REMOTE, 8'h00);
		complete_run();
	end
endmodule
bind pflb_bank pflb_bank_assertions chk_u (.clk(clk), .rstn(rstn), .ce(ce), .bus(bus),
	.events(events), .one_second_strobe(one_second_strobe),
	.monitor_latch_enable(monitor_latch_enable), .rdata(rdata), .rd_ack(rd_ack),
	.faults(faults), .monitors(monitors));
